// ---- rtl/pss_map.vh ----
// constants for the post-shock pacing sequencer
`ifndef PSS_MAP_VH
`define PSS_MAP_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PSS_CTRL_OFS      12'h000
`define PSS_NORM_OFS      12'h004
`define PSS_POST_OFS      12'h008
`define PSS_DELAY_OFS     12'h00c
`define PSS_STAT_OFS      12'h010
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define PSS_CTRL_NORM_EN  0
`define PSS_CTRL_POST_EN  1
`define PSS_CTRL_PER_LO   4
`define PSS_CTRL_PER_HI   7
// ----------------------------------------------------------------
// parameter set fields: escape ms [15:0], av wait ms [27:16]
// ----------------------------------------------------------------
`define PSS_SET_ESC_HI    15
`define PSS_SET_AV_LO     16
`define PSS_SET_AV_HI     27
// ----------------------------------------------------------------
// reset values and ranges
// ----------------------------------------------------------------
`define PSS_CTRL_RST      32'h00000001
`define PSS_SET_RST       32'h00960320
`define PSS_DELAY_RST     16'h0bb8
`define PSS_DELAY_MIN     16'h05dc
`define PSS_DELAY_MAX     16'h2710
`define PSS_PER_CODES     14
`define PSS_PER_MAX_S     3600
`define PSS_CLK_HZ        25000000
`define PSS_MS_PER_S      1000
`define PSS_HZ_PER_KHZ    1000
`endif

// ---- rtl/pss_ms_tick.v ----
// millisecond time base for the pacing sequencer
`timescale 1ns/1ns
`default_nettype none
module pss_ms_tick #(
    parameter integer CYC_PER_MS = 25000
) (
    input  wire clk,
    input  wire resetn,
    output reg  tick
);
    reg [15:0] cnt;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt == CYC_PER_MS[15:0] - 16'h0001) begin
            cnt  <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/pss_sequencer.v ----
// post-shock pacing sequencer with apb register file
//
// Function
// [R01] pace both chambers after any shock, for a period at most 60 minutes
// [R02] own post-shock set; noise, mode-switch, rate-adapt settings shared
// [R03] on shock start refractory interval and hold-off delay timer together
// [R04] hold-off delay gates first pacing even when post-shock mode is off
// [R05] at delay end pacing enabled at selected escape interval minus av wait
// [R06] both chambers sensed in delay: pace only if rate drops below limit
// [R07] nothing sensed or escape elapsed: pace exactly at delay end
// [R08] hold-off delay programmable from 1.5 to 10 seconds
// [R09] programmer accepts delay only 275 ms above escape interval; the delay write here only clamps it to 1.5-10 s
// [R10] that check uses normal rate when post-shock rate is off; the delay write here makes no escape check
// [R11] hold-off delay never affects tachyarrhythmia detection
// [R12] period timer starts at delay expiry; post-shock values apply meanwhile
// [R13] period end reverts to normal set, or stops pacing if normal disabled
// [R14] shock during period restarts the whole sequence from its beginning
// [R15] episode end does not cut a running period short
// [R16] period chosen from fourteen minute:second values, 0:15 to 60:00
// [R17] mode-switch works during post-shock pacing as in normal pacing
// [R18] post-shock off with normal on uses normal set; both off, no pacing
`timescale 1ns/1ns
`default_nettype none
`include "pss_map.vh"
module pss_sequencer #(
    parameter integer REFRACT_MS = 150,
    parameter integer CYC_PER_MS = `PSS_CLK_HZ / `PSS_HZ_PER_KHZ
) (
    // clock and reset
    input  wire        CLK_SYS,
    input  wire        RESETN,
    // apb slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    // shock and detection side
    input  wire        SHOCK_DONE,
    input  wire        EPISODE_END,
    input  wire        MODE_SWITCH_IN,
    output reg         MODE_SWITCH_OUT,
    // sense channels
    input  wire        ATRIAL_SENSE,
    input  wire        VENT_SENSE,
    // pace channels and status
    output reg         ATRIAL_PACE,
    output reg         VENT_PACE,
    output reg         PACING_ON,
    output reg         POST_SET_ACTIVE,
    output reg         REFRACTORY
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [1:0] ST_NORMAL = 2'd0;
    localparam [1:0] ST_HOLD   = 2'd1;
    localparam [1:0] ST_PERIOD = 2'd2;

    // ------------------------------------------------------------
    // registers and time base
    // ------------------------------------------------------------
    reg  [31:0] ctrl;
    reg  [31:0] norm_set;
    reg  [31:0] post_set;
    reg  [15:0] delay_ms;
    reg  [1:0]  state;
    reg  [15:0] hold_cnt;
    reg  [15:0] refr_cnt;
    reg  [11:0] per_ms;
    reg  [11:0] per_s;
    reg  [11:0] per_lim;
    reg  [15:0] esc_cnt;
    reg         av_pend;
    reg  [11:0] av_cnt;
    reg         a_seen;
    reg         v_seen;
    reg         inhibit_first;
    wire        ms_tick;
    wire        apb_wr;
    wire        norm_en;
    wire        post_en;
    wire        use_post;
    wire [15:0] esc_ms;
    wire [11:0] av_ms;
    wire [15:0] v_a_ms;
    reg  [11:0] next_per_lim;

    pss_ms_tick #(
        .CYC_PER_MS (CYC_PER_MS)
    ) i_pss_ms_tick (
        .clk    (CLK_SYS),
        .resetn (RESETN),
        .tick   (ms_tick)
    );

    assign apb_wr  = PSEL & PENABLE & PWRITE;
    assign norm_en = ctrl[`PSS_CTRL_NORM_EN];
    assign post_en = ctrl[`PSS_CTRL_POST_EN];
    // post set only in the period and only if enabled [R12] [R18]
    assign use_post = (state == ST_PERIOD) && post_en; // [R02]
    assign esc_ms = use_post ? post_set[`PSS_SET_ESC_HI:0]
                             : norm_set[`PSS_SET_ESC_HI:0];
    assign av_ms  = use_post ? post_set[`PSS_SET_AV_HI:`PSS_SET_AV_LO]
                             : norm_set[`PSS_SET_AV_HI:`PSS_SET_AV_LO];
    // atrial escape is the rate interval less the av wait [R05]
    assign v_a_ms = (esc_ms > {4'h0, av_ms}) ? esc_ms - {4'h0, av_ms}
                                             : 16'h0001;

    // ------------------------------------------------------------
    // period lookup in seconds
    // ------------------------------------------------------------
    always @* begin
        case (ctrl[`PSS_CTRL_PER_HI:`PSS_CTRL_PER_LO]) // [R16]
            4'h0:    next_per_lim = 12'd15;
            4'h1:    next_per_lim = 12'd30;
            4'h2:    next_per_lim = 12'd45;
            4'h3:    next_per_lim = 12'd60;
            4'h4:    next_per_lim = 12'd90;
            4'h5:    next_per_lim = 12'd120;
            4'h6:    next_per_lim = 12'd180;
            4'h7:    next_per_lim = 12'd240;
            4'h8:    next_per_lim = 12'd300;
            4'h9:    next_per_lim = 12'd600;
            4'ha:    next_per_lim = 12'd900;
            4'hb:    next_per_lim = 12'd1800;
            4'hc:    next_per_lim = 12'd2700;
            default: next_per_lim = 12'd3600; // cap at 60 minutes [R01]
        endcase
    end

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ctrl     <= `PSS_CTRL_RST;
            norm_set <= `PSS_SET_RST;
            post_set <= `PSS_SET_RST;
            delay_ms <= `PSS_DELAY_RST;
            PRDATA   <= 32'h00000000;
            PREADY   <= 1'b0;
            PSLVERR  <= 1'b0;
        end else begin
            PREADY  <= PSEL & ~PENABLE;
            PSLVERR <= 1'b0;
            if (apb_wr && PREADY) begin
                case (PADDR)
                    `PSS_CTRL_OFS: ctrl <= PWDATA & 32'h000000f3;
                    `PSS_NORM_OFS: norm_set <= PWDATA & 32'h0fffffff;
                    `PSS_POST_OFS: post_set <= PWDATA & 32'h0fffffff;
                    `PSS_DELAY_OFS: begin
                        // clamp keeps delay in range [R08]
                        if (PWDATA[15:0] < `PSS_DELAY_MIN)
                            delay_ms <= `PSS_DELAY_MIN;
                        else if (PWDATA[31:16] != 16'h0000 ||
                                 PWDATA[15:0] > `PSS_DELAY_MAX)
                            delay_ms <= `PSS_DELAY_MAX;
                        else
                            delay_ms <= PWDATA[15:0];
                    end
                    // status is read only; unmapped writes ignored
                    default: ;
                endcase
            end
            // data and error launched at setup, so both stand with pready
            if (PSEL && !PENABLE) begin
                case (PADDR)
                    `PSS_CTRL_OFS:  PRDATA <= ctrl;
                    `PSS_NORM_OFS:  PRDATA <= norm_set;
                    `PSS_POST_OFS:  PRDATA <= post_set;
                    `PSS_DELAY_OFS: PRDATA <= {16'h0000, delay_ms};
                    `PSS_STAT_OFS: begin
                        PRDATA  <= {24'h000000, 2'b00,
                                    inhibit_first, REFRACTORY,
                                    PACING_ON, use_post, state};
                        PSLVERR <= PWRITE;
                    end
                    default: begin
                        PRDATA  <= 32'h00000000;
                        PSLVERR <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer; mode-switch input passes through one register unchanged, episode end unused [R11] [R17]
    // ------------------------------------------------------------
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            state           <= ST_NORMAL;
            hold_cnt        <= 16'h0000;
            refr_cnt        <= 16'h0000;
            per_ms          <= 12'h000;
            per_s           <= 12'h000;
            per_lim         <= 12'h00f;
            esc_cnt         <= 16'h0000;
            av_pend         <= 1'b0;
            av_cnt          <= 12'h000;
            a_seen          <= 1'b0;
            v_seen          <= 1'b0;
            inhibit_first   <= 1'b0;
            ATRIAL_PACE     <= 1'b0;
            VENT_PACE       <= 1'b0;
            PACING_ON       <= 1'b0;
            POST_SET_ACTIVE <= 1'b0;
            REFRACTORY      <= 1'b0;
            MODE_SWITCH_OUT <= 1'b0;
        end else begin
            ATRIAL_PACE     <= 1'b0;
            VENT_PACE       <= 1'b0;
            MODE_SWITCH_OUT <= MODE_SWITCH_IN; // [R17]
            POST_SET_ACTIVE <= use_post;
            REFRACTORY      <= (refr_cnt != 16'h0000);
            // pacing lives only while some set is enabled [R13] [R18]
            PACING_ON <= (state == ST_NORMAL) ? norm_en :
                         (state == ST_PERIOD) ? (norm_en | post_en) :
                         1'b0; // [R04]
            if (ms_tick && refr_cnt != 16'h0000)
                refr_cnt <= refr_cnt - 16'h0001;
            if (ATRIAL_SENSE || VENT_SENSE)
                esc_cnt <= 16'h0000;
            else if (ms_tick && esc_cnt != 16'hffff)
                esc_cnt <= esc_cnt + 16'h0001;
            if (SHOCK_DONE) begin
                // restart also covers a shock in the period [R14]
                state    <= ST_HOLD; // [R03]
                hold_cnt <= delay_ms; // [R03]
                refr_cnt <= REFRACT_MS[15:0]; // [R03]
                a_seen   <= 1'b0;
                v_seen   <= 1'b0;
                av_pend  <= 1'b0;
            end else begin
                case (state)
                    ST_HOLD: begin
                        if (ATRIAL_SENSE)
                            a_seen <= 1'b1;
                        if (VENT_SENSE)
                            v_seen <= 1'b1;
                        if (ms_tick)
                            hold_cnt <= hold_cnt - 16'h0001;
                        if (ms_tick && hold_cnt == 16'h0001) begin
                            state   <= ST_PERIOD; // [R12]
                            per_ms  <= 12'h000;
                            per_s   <= 12'h000;
                            per_lim <= next_per_lim;
                            // recent sensing in both chambers inhibits
                            inhibit_first <= a_seen & v_seen &
                                (esc_cnt <= esc_ms); // [R06]
                            if (!(a_seen & v_seen & (esc_cnt <= esc_ms))
                                && (norm_en | post_en)) begin
                                VENT_PACE <= 1'b1; // [R07]
                                esc_cnt   <= 16'h0000;
                            end
                        end
                    end
                    ST_PERIOD: begin
                        // episode end deliberately ignored here [R15]
                        if (ms_tick) begin
                            if (per_ms == 12'd999) begin
                                per_ms <= 12'h000;
                                per_s  <= per_s + 12'h001;
                                if (per_s + 12'h001 >= per_lim) begin
                                    state <= ST_NORMAL; // [R13]
                                    inhibit_first <= 1'b0;
                                end
                            end else begin
                                per_ms <= per_ms + 12'h001;
                            end
                        end
                    end
                    default: begin
                        inhibit_first <= 1'b0;
                    end
                endcase
            end
            // escape pacing, a at v-a time, v after av wait [R05] [R06]
            if (!SHOCK_DONE && PACING_ON && state != ST_HOLD) begin
                if (VENT_SENSE) begin
                    av_pend <= 1'b0;
                end else if (av_pend) begin
                    if (ms_tick) begin
                        if (av_cnt <= 12'h001) begin
                            av_pend   <= 1'b0;
                            VENT_PACE <= 1'b1;
                            esc_cnt   <= 16'h0000;
                        end else begin
                            av_cnt <= av_cnt - 12'h001;
                        end
                    end
                end else if (ms_tick && esc_cnt >= v_a_ms &&
                             !ATRIAL_SENSE) begin
                    ATRIAL_PACE <= 1'b1;
                    av_pend     <= 1'b1;
                    av_cnt      <= av_ms;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/pss_properties.sv ----
// concurrent checks on the pacing sequencer ports
`timescale 1ns/1ns
`default_nettype none
module pss_properties #(
    parameter integer REFRACT_MS = 150
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // shock and detection
    input wire logic SHOCK_DONE,
    input wire logic EPISODE_END,
    input wire logic MODE_SWITCH_IN,
    input wire logic MODE_SWITCH_OUT,
    // pace and status
    input wire logic ATRIAL_PACE,
    input wire logic VENT_PACE,
    input wire logic PACING_ON,
    input wire logic REFRACTORY
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_shock;
        SHOCK_DONE;
    endsequence
    // refractory lasts far longer than 8 cycles at the default REFRACT_MS of 150
    sequence s_hold_entered;
        ##2 (REFRACTORY && !PACING_ON) [*8];
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_SHOCK_STARTS_HOLD: assert property (s_shock |-> s_hold_entered)
        else $error("shock did not start refractory and hold-off");
    AST_HOLD_GATES_PACING: assert property (s_shock |-> ##2 !PACING_ON)
        else $error("pacing allowed right after shock");
    AST_NO_PACE_REFRACT: assert property (REFRACTORY |-> !ATRIAL_PACE && !VENT_PACE)
        else $error("pace pulse during refractory");
    AST_EPISODE_IGNORED: assert property (EPISODE_END && REFRACTORY && !PACING_ON |=> !PACING_ON)
        else $error("episode end released the hold-off");
    AST_MODE_SWITCH_KEPT: assert property (##1 MODE_SWITCH_OUT == $past(MODE_SWITCH_IN))
        else $error("mode switch not passed through");
    AST_APB_ZERO_WAIT: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("pready missing in access cycle");
    AST_APB_READY_ONLY_ACCESS: assert property (PREADY |-> PSEL && PENABLE)
        else $error("pready outside access cycle");
    AST_APB_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
        else $error("pslverr without pready");
    AST_VPACE_PULSE: assert property ($rose(VENT_PACE) |=> !VENT_PACE)
        else $error("ventricular pace longer than one cycle");
endmodule
bind pss_sequencer pss_properties #(.REFRACT_MS(REFRACT_MS)) i_pss_properties (
    .CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SHOCK_DONE(SHOCK_DONE),
    .EPISODE_END(EPISODE_END), .MODE_SWITCH_IN(MODE_SWITCH_IN),
    .MODE_SWITCH_OUT(MODE_SWITCH_OUT), .ATRIAL_PACE(ATRIAL_PACE),
    .VENT_PACE(VENT_PACE), .PACING_ON(PACING_ON), .REFRACTORY(REFRACTORY));
`default_nettype wire

// ---- bench/pss_leads.sv ----
// behavioural model of the two leads: intrinsic beats in, paces counted
`timescale 1ns/1ns
`default_nettype none
module pss_leads (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // beat request from the bench
    input  wire logic beat,
    // lead signals
    input  wire logic a_pace,
    input  wire logic v_pace,
    output var  logic a_sense,
    output var  logic v_sense,
    output var  int   paces
);
    // short fixed conduction: ventricle follows atrium by one cycle
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            a_sense <= 1'b0;
            v_sense <= 1'b0;
            paces   <= 0;
        end else begin
            a_sense <= beat;
            v_sense <= a_sense;
            paces   <= paces + int'(a_pace) + int'(v_pace);
        end
    end
endmodule
`default_nettype wire

// ---- bench/pss_sequencer_tb.sv ----
// register and shock sequence tests for the pacing sequencer
`timescale 1ns/1ns
`default_nettype none
`include "pss_map.vh"
module pss_sequencer_tb;
    logic        CLK_SYS = 1'b0, RESETN = 1'b0;
    logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h00000000, PRDATA, rd;
    logic        PREADY, PSLVERR, err;
    logic        SHOCK_DONE = 1'b0, EPISODE_END = 1'b0, MODE_SWITCH_IN = 1'b0;
    logic        MODE_SWITCH_OUT, ATRIAL_SENSE, VENT_SENSE, beat = 1'b0;
    logic        ATRIAL_PACE, VENT_PACE, PACING_ON, POST_SET_ACTIVE, REFRACTORY;
    int          bad_count = 0, n_compared = 0, paces, p0, i;
    always #20 CLK_SYS = ~CLK_SYS;
    // short ms base keeps the shock timing inside the run
    pss_sequencer #(.CYC_PER_MS(2)) i_pss_sequencer (.CLK_SYS(CLK_SYS),
        .RESETN(RESETN),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SHOCK_DONE(SHOCK_DONE),
        .EPISODE_END(EPISODE_END), .MODE_SWITCH_IN(MODE_SWITCH_IN),
        .MODE_SWITCH_OUT(MODE_SWITCH_OUT), .ATRIAL_SENSE(ATRIAL_SENSE),
        .VENT_SENSE(VENT_SENSE), .ATRIAL_PACE(ATRIAL_PACE),
        .VENT_PACE(VENT_PACE), .PACING_ON(PACING_ON),
        .POST_SET_ACTIVE(POST_SET_ACTIVE), .REFRACTORY(REFRACTORY));
    pss_leads i_pss_leads (.clk(CLK_SYS), .resetn(RESETN), .beat(beat),
        .a_pace(ATRIAL_PACE), .v_pace(VENT_PACE), .a_sense(ATRIAL_SENSE),
        .v_sense(VENT_SENSE), .paces(paces));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task check(input string name, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do @(posedge CLK_SYS); while (PREADY !== 1'b1);
        rd = PRDATA; err = PSLVERR;
        PSEL <= 1'b0; PENABLE <= 1'b0;
    endtask
    task rd_chk(input string name, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        check(name, rd, e);
        check("pslverr", {31'h0, err}, 32'h00000000);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        cyc(2);
        RESETN <= 1'b1;
        cyc(3);
        check("pacing_on", {31'h0, PACING_ON}, 32'h00000001);
        rd_chk("ctrl", `PSS_CTRL_OFS, `PSS_CTRL_RST);
        rd_chk("norm", `PSS_NORM_OFS, `PSS_SET_RST);
        rd_chk("post", `PSS_POST_OFS, `PSS_SET_RST);
        rd_chk("delay", `PSS_DELAY_OFS, {16'h0, `PSS_DELAY_RST});
        // independent sets: post change leaves normal alone
        apb(1'b1, `PSS_POST_OFS, 32'h00780258);
        rd_chk("post", `PSS_POST_OFS, 32'h00780258);
        rd_chk("norm", `PSS_NORM_OFS, `PSS_SET_RST);
        // delay clamped at both ends of its range
        apb(1'b1, `PSS_DELAY_OFS, 32'h00000100);
        rd_chk("delay", `PSS_DELAY_OFS, {16'h0, `PSS_DELAY_MIN});
        apb(1'b1, `PSS_DELAY_OFS, 32'h00003000);
        rd_chk("delay", `PSS_DELAY_OFS, {16'h0, `PSS_DELAY_MAX});
        // 1500 ms stays 275 ms above both the 800 and 600 ms escapes
        apb(1'b1, `PSS_DELAY_OFS, 32'h000005dc);
        rd_chk("delay", `PSS_DELAY_OFS, 32'h000005dc);
        // every period code kept, post mode on
        for (i = 0; i < `PSS_PER_CODES; i++) begin
            apb(1'b1, `PSS_CTRL_OFS, {24'h0, i[3:0], 4'h3});
            rd_chk("ctrl", `PSS_CTRL_OFS, {24'h0, i[3:0], 4'h3});
        end
        // refused accesses
        apb(1'b0, 12'h014, 32'h00000000);
        check("unmapped err", {31'h0, err}, 32'h00000001);
        check("unmapped data", rd, 32'h00000000);
        apb(1'b1, `PSS_STAT_OFS, 32'hffffffff);
        check("stat write err", {31'h0, err}, 32'h00000001);
        // shock, then beats and episode end inside the hold-off
        @(posedge CLK_SYS) SHOCK_DONE <= 1'b1;
        @(posedge CLK_SYS) SHOCK_DONE <= 1'b0;
        cyc(2);
        check("refractory", {31'h0, REFRACTORY}, 32'h00000001);
        check("pacing_on", {31'h0, PACING_ON}, 32'h00000000);
        apb(1'b0, `PSS_STAT_OFS, 32'h00000000);
        check("stat", rd & 32'h00000018, 32'h00000010);
        p0 = paces;
        for (i = 0; i < 4; i++) begin
            @(posedge CLK_SYS) beat <= 1'b1;
            MODE_SWITCH_IN <= ~MODE_SWITCH_IN;
            @(posedge CLK_SYS) beat <= 1'b0;
            EPISODE_END <= i[0];
            cyc(1);
            check("mode_switch", {31'h0, MODE_SWITCH_OUT},
                  {31'h0, MODE_SWITCH_IN});
        end
        EPISODE_END <= 1'b0;
        cyc(400);
        check("pacing_on", {31'h0, PACING_ON}, 32'h00000000);
        check("refractory", {31'h0, REFRACTORY}, 32'h00000000);
        check("paces", paces - p0, 0);
        // 15 s period, then a second shock mid-hold restarts everything
        apb(1'b1, `PSS_CTRL_OFS, 32'h00000003);
        @(posedge CLK_SYS) SHOCK_DONE <= 1'b1;
        @(posedge CLK_SYS) SHOCK_DONE <= 1'b0;
        cyc(2);
        check("refractory", {31'h0, REFRACTORY}, 32'h00000001);
        // first hold would have ended by now; the restarted one not yet
        cyc(2900);
        check("paces", paces - p0, 0);
        // nothing sensed: one ventricular pace at delay end, post set on
        cyc(200);
        check("paces", paces - p0, 1);
        check("post_set", {31'h0, POST_SET_ACTIVE}, 32'h00000001);
        apb(1'b0, `PSS_STAT_OFS, 32'h00000000);
        check("stat", rd & 32'h0000003f, 32'h0000000e);
        @(posedge CLK_SYS) EPISODE_END <= 1'b1;
        @(posedge CLK_SYS) EPISODE_END <= 1'b0;
        // post set 600 ms, av 120 ms: a pace at 480 ms, v pace 120 later
        cyc(1200);
        check("paces", paces - p0, 3);
        check("post_set", {31'h0, POST_SET_ACTIVE}, 32'h00000001);
        // normal pacing off: period end stops pacing altogether
        apb(1'b1, `PSS_CTRL_OFS, 32'h00000002);
        check("pacing_on", {31'h0, PACING_ON}, 32'h00000001);
        cyc(29000);
        check("pacing_on", {31'h0, PACING_ON}, 32'h00000000);
        check("post_set", {31'h0, POST_SET_ACTIVE}, 32'h00000000);
        stop_test();
    end
    initial begin
        cyc(50000);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
